// *** hw/fpu_register_move_unit.v ***
// float register move unit: moves between eight float registers and the
// host product register and accumulator, conditional moves from memory
// and register to register, status flags, alignment checks, AXI4-Lite.
// assumes the host core issues at most one move per cycle on aclk and
// honours the alignment delays; violations are only reported.
`include "fpu_move_map.vh"
module fpu_register_move_unit #(
    parameter DATA_W = 32,
    parameter IDX_W  = 3,
    parameter NREG   = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    // issue port from the host pipeline
    input  wire              instr_valid,
    input  wire [2:0]        instr_op,
    input  wire              cond_given,
    input  wire [3:0]        move_condition_field,
    input  wire [IDX_W-1:0]  fpu_dest_reg,
    input  wire [IDX_W-1:0]  fpu_src_reg,
    input  wire [DATA_W-1:0] memory_operand_word,
    input  wire [DATA_W-1:0] host_acc_in,
    input  wire [DATA_W-1:0] host_prod_in,
    // arithmetic units report issue of results into float registers
    input  wire              arith_issue,
    input  wire              arith_two_cycle,
    input  wire [IDX_W-1:0]  arith_dest,
    input  wire              arith_flags_we,
    input  wire [6:0]        arith_flags,
    // results toward the host core
    output reg  [DATA_W-1:0] host_prod_out,
    output reg               host_prod_we,
    output reg  [DATA_W-1:0] host_acc_out,
    output reg               host_acc_we,
    output wire [6:0]        fpu_status_register,
    output wire [NREG-1:0]   reg_pending,
    output wire              irq,
    // AXI4-Lite slave
    input  wire [4:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [4:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);

    // condition evaluation, shared by both conditional moves
    function cond_true;
        input [3:0] code;
        input [6:0] f;
        begin
            case (code)
                `COND_NONZERO:      cond_true = !f[`FLAG_ZERO];
                `COND_ZERO:         cond_true = f[`FLAG_ZERO];
                `COND_POSITIVE:     cond_true = !f[`FLAG_ZERO] && !f[`FLAG_NEG];
                `COND_NONNEGATIVE:  cond_true = !f[`FLAG_NEG];
                `COND_NEGATIVE:     cond_true = f[`FLAG_NEG];
                `COND_NONPOSITIVE:  cond_true = f[`FLAG_ZERO] && f[`FLAG_NEG];
                `COND_TEST_SET:     cond_true = f[`FLAG_TEST];
                `COND_TEST_CLEAR:   cond_true = !f[`FLAG_TEST];
                `COND_LATCHED_UF:   cond_true = f[`FLAG_UNDERFLOW];
                `COND_LATCHED_OF:   cond_true = f[`FLAG_OVERFLOW];
                `COND_ALWAYS:       cond_true = 1'b1;
                `COND_ALWAYS_FLAGS: cond_true = 1'b1;
                default:            cond_true = 1'b0; // reserved codes never move
            endcase
        end
    endfunction

    // reserved codes 6..9 are reported and treated as false
    function cond_reserved;
        input [3:0] code;
        begin
            cond_reserved = (code > `COND_NONPOSITIVE) && (code < `COND_TEST_SET);
        end
    endfunction

    // does this operation read a float register as its source
    function reads_float;
        input [2:0] op;
        begin
            reads_float = (op == `OP_FLOAT_TO_PROD) || (op == `OP_FLOAT_TO_ACC) ||
                          (op == `OP_REG_COND);
        end
    endfunction

    // ---------------- control and status state ----------------
    reg              enable_r;
    reg [6:0]        flags_r;
    reg [6:0]        flags_nxt;
    reg [`EVT_W-1:0] evt_stat_r;
    reg [`EVT_W-1:0] evt_mask_r;
    reg [`EVT_W-1:0] evt_set;

    // issue stage, registered into the execute stage
    reg              ex_valid_r;
    reg [2:0]        ex_op_r;
    reg [3:0]        ex_cond_r;
    reg [IDX_W-1:0]  ex_dest_r;
    reg [DATA_W-1:0] ex_word_r;

    wire [DATA_W-1:0] rd_src_data;
    wire [DATA_W-1:0] rd_dst_data;
    reg               rf_we;
    reg  [DATA_W-1:0] rf_wdata;

    wire            take = instr_valid && enable_r;
    // no condition given means the flag-modifying unconditional code
    wire [3:0]      eff_cond = cond_given ? move_condition_field : `COND_ALWAYS_FLAGS;

    // ---------------- alignment tracking per register ----------------
    // each register carries a count of cycles before it may be read; the
    // host is trusted to wait, the unit only flags a read made too early
    reg  [2:0]      wait_cnt_r [0:NREG-1];
    reg  [2:0]      host_shadow_r;
    wire [NREG-1:0] busy;
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : align_track
            wire host_load = take && (instr_op == `OP_ACC_TO_FLOAT ||
                             instr_op == `OP_PROD_TO_FLOAT) && fpu_dest_reg == g;
            wire arith_load = arith_issue && arith_dest == g;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    wait_cnt_r[g] <= 3'h0;
                end else if (host_load) begin
                    wait_cnt_r[g] <= `ALIGN_HOST_TO_FLOAT;
                end else if (arith_load) begin
                    wait_cnt_r[g] <= arith_two_cycle ? `ALIGN_TWO_CYCLE_OP
                                                     : `ALIGN_ONE_CYCLE_OP;
                end else if (wait_cnt_r[g] != 3'h0) begin
                    wait_cnt_r[g] <= wait_cnt_r[g] - 3'h1;
                end
            end
            assign busy[g] = wait_cnt_r[g] != 3'h0;
        end
    endgenerate
    assign reg_pending = busy;

    // conversion shadow: four cycles after any host-to-float copy
    always @(posedge aclk) begin
        if (!aresetn) begin
            host_shadow_r <= 3'h0;
        end else if (take && (instr_op == `OP_ACC_TO_FLOAT ||
                              instr_op == `OP_PROD_TO_FLOAT)) begin
            host_shadow_r <= `ALIGN_HOST_TO_FLOAT;
        end else if (host_shadow_r != 3'h0) begin
            host_shadow_r <= host_shadow_r - 3'h1;
        end
    end

    // ---------------- issue to execute register ----------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ex_valid_r <= 1'b0;
            ex_op_r    <= `OP_NONE;
            ex_cond_r  <= `COND_ALWAYS_FLAGS;
            ex_dest_r  <= {IDX_W{1'b0}};
            ex_word_r  <= {DATA_W{1'b0}};
        end else begin
            ex_valid_r <= take;
            ex_op_r    <= take ? instr_op : `OP_NONE;
            ex_cond_r  <= eff_cond;
            ex_dest_r  <= fpu_dest_reg;
            // the word to be written is chosen now; register reads land
            // in the execute stage straight from the register file
            case (instr_op)
                `OP_ACC_TO_FLOAT:  ex_word_r <= host_acc_in;
                `OP_PROD_TO_FLOAT: ex_word_r <= host_prod_in;
                default:           ex_word_r <= memory_operand_word;
            endcase
        end
    end

    // source register read in the issue cycle, data in the execute cycle
    fpu_reg_file #(
        .DATA_W (DATA_W),
        .IDX_W  (IDX_W)
    ) u_regs (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .we        (rf_we),
        .wr_idx    (ex_dest_r),
        .wr_data   (rf_wdata),
        .rd_a_idx  (fpu_src_reg),
        .rd_b_idx  (fpu_dest_reg),
        .rd_a_data (rd_src_data),
        .rd_b_data (rd_dst_data)
    );

    // ---------------- execute: condition, write, flags ----------------
    wire            ex_cond_op = ex_op_r == `OP_MEM_COND || ex_op_r == `OP_REG_COND;
    wire            ex_hit     = cond_true(ex_cond_r, flags_r);
    wire [DATA_W-1:0] ex_result = (ex_op_r == `OP_REG_COND) ? rd_src_data : ex_word_r;

    always @* begin
        rf_we     = 1'b0;
        rf_wdata  = ex_result;
        flags_nxt = flags_r;
        // arithmetic units own the flags in cycles without a flag move
        if (arith_flags_we)
            flags_nxt = arith_flags;
        if (ex_valid_r) begin
            case (ex_op_r)
                `OP_ACC_TO_FLOAT, `OP_PROD_TO_FLOAT: begin
                    rf_we = 1'b1;
                end
                `OP_MEM_COND, `OP_REG_COND: begin
                    rf_we = ex_hit;
                    // only the flag-modifying code touches the four result
                    // flags; test and latched flags are never written here
                    if (ex_cond_r == `COND_ALWAYS_FLAGS) begin
                        flags_nxt[`FLAG_NEG]      = ex_result[`SIGN_BIT];
                        flags_nxt[`FLAG_ZERO]     = 1'b0;
                        if (ex_result[`EXP_HI:`EXP_LO] == 8'h00) begin
                            flags_nxt[`FLAG_ZERO] = 1'b1;
                            flags_nxt[`FLAG_NEG]  = 1'b0;
                        end
                        flags_nxt[`FLAG_INT_NEG]  = ex_result[`SIGN_BIT];
                        flags_nxt[`FLAG_INT_ZERO] = ex_result == {DATA_W{1'b0}};
                    end
                end
                default: begin
                    rf_we = 1'b0;
                end
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            flags_r <= `FLAG_RESET;
        else
            flags_r <= flags_nxt;
    end
    assign fpu_status_register = flags_r;

    // copies toward the host: full word, flags untouched, one-cycle strobe
    always @(posedge aclk) begin
        if (!aresetn) begin
            host_prod_out <= {DATA_W{1'b0}};
            host_prod_we  <= 1'b0;
            host_acc_out  <= {DATA_W{1'b0}};
            host_acc_we   <= 1'b0;
        end else begin
            host_prod_we <= ex_valid_r && ex_op_r == `OP_FLOAT_TO_PROD;
            host_acc_we  <= ex_valid_r && ex_op_r == `OP_FLOAT_TO_ACC;
            if (ex_valid_r && ex_op_r == `OP_FLOAT_TO_PROD)
                host_prod_out <= rd_src_data;
            if (ex_valid_r && ex_op_r == `OP_FLOAT_TO_ACC)
                host_acc_out  <= rd_src_data;
        end
    end

    // ---------------- events ----------------
    // the destination port read is kept only to show the value the host
    // would lose; the unit does not use it for decisions
    always @* begin
        evt_set = {`EVT_W{1'b0}};
        evt_set[`EVT_MOVE_DONE]  = ex_valid_r && ex_op_r != `OP_CONVERT &&
                                   ex_op_r != `OP_NONE && (!ex_cond_op || ex_hit);
        evt_set[`EVT_COND_FALSE] = ex_valid_r && ex_cond_op && !ex_hit;
        evt_set[`EVT_RESERVED]   = ex_valid_r && ex_cond_op && cond_reserved(ex_cond_r);
        evt_set[`EVT_ALIGN]      = take && (instr_op == `OP_FLOAT_TO_PROD ||
                                   instr_op == `OP_FLOAT_TO_ACC) && busy[fpu_src_reg];
        evt_set[`EVT_CONVERT_SHADOW] = take && instr_op == `OP_CONVERT &&
                                       host_shadow_r != 3'h0;
        evt_set[`EVT_USE_EARLY]  = take && instr_op == `OP_REG_COND &&
                                   busy[fpu_src_reg];
    end

    // ---------------- AXI4-Lite slave ----------------
    // address and data are taken together; a write waits until both are
    // offered and the previous response has gone
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_take = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_map = s_axi_awaddr == `ADDR_CTRL || s_axi_awaddr == `ADDR_EVT_STAT ||
                  s_axi_awaddr == `ADDR_EVT_MASK || s_axi_awaddr == `ADDR_FLAGS ||
                  s_axi_awaddr == `ADDR_PENDING;
    wire wr_ctrl = wr_take && s_axi_awaddr == `ADDR_CTRL && s_axi_wstrb[0];
    wire wr_stat = wr_take && s_axi_awaddr == `ADDR_EVT_STAT && s_axi_wstrb[0];
    wire wr_mask = wr_take && s_axi_awaddr == `ADDR_EVT_MASK && s_axi_wstrb[0];

    // control and mask registers; writing a one clears a status bit,
    // but an event in the same cycle keeps it set
    always @(posedge aclk) begin
        if (!aresetn) begin
            enable_r   <= 1'b1;
            evt_mask_r <= {`EVT_W{1'b0}};
            evt_stat_r <= {`EVT_W{1'b0}};
        end else begin
            if (wr_ctrl)
                enable_r <= s_axi_wdata[0];
            if (wr_mask)
                evt_mask_r <= s_axi_wdata[`EVT_W-1:0];
            evt_stat_r <= (evt_stat_r & ~(wr_stat ? s_axi_wdata[`EVT_W-1:0]
                                                  : {`EVT_W{1'b0}})) | evt_set;
        end
    end
    assign irq = |(evt_stat_r & evt_mask_r);

    // write response, one cycle after the take
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data, one cycle after the take; unmapped reads return zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
                `ADDR_CTRL:     s_axi_rdata <= {31'h0, enable_r};
                `ADDR_FLAGS:    s_axi_rdata <= {25'h0, flags_r};
                `ADDR_EVT_STAT: s_axi_rdata <= {26'h0, evt_stat_r};
                `ADDR_EVT_MASK: s_axi_rdata <= {26'h0, evt_mask_r};
                `ADDR_PENDING:  s_axi_rdata <= {24'h0, busy};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // rd_dst_data is a spare read port kept for debug visibility only
    wire unused_dst = ^rd_dst_data;
endmodule

// *** common/fpu_move_map.vh ***
// constants for the float register move unit: opcodes, condition codes,
// flag positions, alignment counts and the register map.
// assumes inclusion by bare name from the design files.
`ifndef FPU_MOVE_MAP_VH
`define FPU_MOVE_MAP_VH

// move operations presented on the issue port
`define OP_FLOAT_TO_PROD    3'h0
`define OP_FLOAT_TO_ACC     3'h1
`define OP_ACC_TO_FLOAT     3'h2
`define OP_PROD_TO_FLOAT    3'h3
`define OP_MEM_COND         3'h4
`define OP_REG_COND         3'h5
`define OP_CONVERT          3'h6
`define OP_NONE             3'h7

// condition codes of move_condition_field
`define COND_NONZERO        4'h0
`define COND_ZERO           4'h1
`define COND_POSITIVE       4'h2
`define COND_NONNEGATIVE    4'h3
`define COND_NEGATIVE       4'h4
`define COND_NONPOSITIVE    4'h5
`define COND_TEST_SET       4'ha
`define COND_TEST_CLEAR     4'hb
`define COND_LATCHED_UF     4'hc
`define COND_LATCHED_OF     4'hd
`define COND_ALWAYS         4'he
`define COND_ALWAYS_FLAGS   4'hf

// fpu_status_register bit positions
`define FLAG_OVERFLOW       0
`define FLAG_UNDERFLOW      1
`define FLAG_NEG            2
`define FLAG_ZERO           3
`define FLAG_INT_NEG        4
`define FLAG_INT_ZERO       5
`define FLAG_TEST           6
`define FLAG_W              7
`define FLAG_RESET          7'h00

// result fields looked at by the flag update
`define SIGN_BIT            31
`define EXP_HI              30
`define EXP_LO              23

// alignment counts in cycles
`define ALIGN_ONE_CYCLE_OP  3'h1
`define ALIGN_TWO_CYCLE_OP  3'h2
`define ALIGN_HOST_TO_FLOAT 3'h4

// register map, byte addresses
`define ADDR_CTRL           5'h00
`define ADDR_FLAGS          5'h04
`define ADDR_EVT_STAT       5'h08
`define ADDR_EVT_MASK       5'h0c
`define ADDR_PENDING        5'h10
`define EVT_W               6
`define EVT_MOVE_DONE       0
`define EVT_COND_FALSE      1
`define EVT_RESERVED        2
`define EVT_ALIGN           3
`define EVT_CONVERT_SHADOW  4
`define EVT_USE_EARLY       5
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** hw/fpu_reg_file.v ***
// eight-entry float register file, one write port, two read ports.
// assumes one clock; read data come from flip-flops one cycle after the
// address, and a write to the address being read is forwarded.
module fpu_reg_file #(
    parameter DATA_W = 32,
    parameter IDX_W  = 3
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              we,
    input  wire [IDX_W-1:0]  wr_idx,
    input  wire [DATA_W-1:0] wr_data,
    input  wire [IDX_W-1:0]  rd_a_idx,
    input  wire [IDX_W-1:0]  rd_b_idx,
    output reg  [DATA_W-1:0] rd_a_data,
    output reg  [DATA_W-1:0] rd_b_data
);
    reg [DATA_W-1:0] mem [0:(1<<IDX_W)-1];
    integer i;

    // storage; reset clears every entry so reads are never unknown
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < (1<<IDX_W); i = i + 1)
                mem[i] <= {DATA_W{1'b0}};
        end else if (we) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // registered reads with write forwarding, so back-to-back moves see
    // the value just written rather than the stale entry
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_a_data <= {DATA_W{1'b0}};
            rd_b_data <= {DATA_W{1'b0}};
        end else begin
            rd_a_data <= (we && wr_idx == rd_a_idx) ? wr_data : mem[rd_a_idx];
            rd_b_data <= (we && wr_idx == rd_b_idx) ? wr_data : mem[rd_b_idx];
        end
    end
endmodule

// *** verif/fpu_move_checker.sv ***
// checker for the float register move unit, bound onto its top ports.
// assumes the issue enable keeps its reset value and arith flags stay idle.
module fpu_move_checker (
    input logic        aclk,
    input logic        aresetn,
    input logic        instr_valid,
    input logic [2:0]  instr_op,
    input logic        cond_given,
    input logic [3:0]  move_condition_field,
    input logic [2:0]  fpu_dest_reg,
    input logic [31:0] memory_operand_word,
    input logic        arith_flags_we,
    input logic        host_prod_we,
    input logic [6:0]  fpu_status_register,
    input logic [7:0]  reg_pending,
    input logic        s_axi_awvalid,
    input logic        s_axi_wvalid,
    input logic        s_axi_bvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // int zero, int neg, zero, neg as a flag-updating move must leave them
    function automatic logic [3:0] fb(input logic [31:0] w);
        return {w == 32'h0, w[31], w[30:23] == 8'h00, w[31] && w[30:23] != 8'h00};
    endfunction
    AST_PROD_LATENCY: assert property (instr_valid && instr_op == 3'h0 |-> ##2 host_prod_we)
        else $error("product strobe missing");
    AST_PROD_CAUSE: assert property (host_prod_we |-> $past(instr_valid, 2))
        else $error("product strobe without a copy");
    // flags move at the edge after the taking edge, so the window is one cycle later
    AST_PROD_FLAGS: assert property (instr_valid && instr_op == 3'h0 && !arith_flags_we
        |=> ##1 $stable(fpu_status_register)) else $error("product copy changed flags");
    AST_COND_NO_FLAGS: assert property (instr_valid && instr_op[2:1] == 2'b10 && cond_given
        && move_condition_field != 4'hf && !arith_flags_we |=> ##1 $stable(fpu_status_register))
        else $error("flags changed by a non-flag code");
    AST_FLAG_UPDATE: assert property (instr_valid && instr_op == 3'h4 && !cond_given
        |=> ##1 fpu_status_register[5:2] == fb($past(memory_operand_word, 2)))
        else $error("flag update wrong");
    AST_LATCH_KEEP: assert property (instr_valid && instr_op == 3'h4 && !arith_flags_we
        |=> ##1 $stable(fpu_status_register[6]) && $stable(fpu_status_register[1:0]))
        else $error("test or latched flag altered");
    AST_PENDING: assert property (instr_valid && instr_op == 3'h2 && fpu_dest_reg == 3'h3
        |=> reg_pending[3] [*4] ##1 !reg_pending[3]) else $error("pending window wrong");
    AST_WRITE_RESP: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_bvalid) else $error("write response missing");
endmodule
bind fpu_register_move_unit fpu_move_checker chk (.*);

// *** verif/host_core_model.sv ***
// host core model: product register and accumulator facing the move unit.
// assumes one-cycle write strobes from the move unit on aclk.
module host_core_model (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic [31:0] prod_out,
    input  logic        prod_we,
    input  logic [31:0] acc_out,
    input  logic        acc_we,
    output logic [31:0] acc_r,
    output logic [31:0] prod_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // core registers take a copy only at the edge its strobe is sampled
    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 32'h0;
            prod_r <= 32'h0;
        end else begin
            if (acc_we) acc_r <= acc_out;
            if (prod_we) prod_r <= prod_out;
        end
    end
endmodule

// *** verif/fpu_register_move_unit_tb_top.sv ***
// bench for the float register move unit with a float register model.
// assumes the host core model and the bound checker beside the design.
`include "fpu_move_map.vh"
module fpu_register_move_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, instr_valid = 0, cond_given = 0, irq;
    logic [2:0]  instr_op = 0, fpu_dest_reg = 0, fpu_src_reg = 0;
    logic [3:0]  move_condition_field = 0, s_axi_wstrb = 4'hf;
    logic [31:0] memory_operand_word = 0, host_acc_in, host_prod_in, host_prod_out;
    logic [31:0] host_acc_out, s_axi_wdata = 0, s_axi_rdata, rnd = 32'h7c60b281, rd;
    logic        host_prod_we, host_acc_we, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_arready, s_axi_rvalid, ok;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [6:0]  fpu_status_register, fl = 0;
    logic [7:0]  reg_pending;
    logic [31:0] fr [8] = '{default: 32'h0};
    int          mismatches = 0, checks = 0;
    fpu_register_move_unit dut (.*, .arith_issue(1'b0), .arith_two_cycle(1'b0),
        .arith_dest(3'h0), .arith_flags_we(1'b0), .arith_flags(7'h00));
    host_core_model host (.aclk(aclk), .aresetn(aresetn), .prod_out(host_prod_out),
        .prod_we(host_prod_we), .acc_out(host_acc_out), .acc_we(host_acc_we),
        .acc_r(host_acc_in), .prod_r(host_prod_in));
    // 250 MHz clock
    initial forever #2 aclk = ~aclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one issue cycle; returns at the taking edge
    task automatic issue(input logic [2:0] op, input logic [3:0] c, input logic cg,
                         input logic [2:0] d, input logic [2:0] s, input logic [31:0] w);
        @(posedge aclk);
        instr_valid <= 1; instr_op <= op; cond_given <= cg; move_condition_field <= c;
        fpu_dest_reg <= d; fpu_src_reg <= s; memory_operand_word <= w;
        @(posedge aclk);
        instr_valid <= 0;
    endtask
    // reserved codes never pass, so a stale flag can not leak a write
    function automatic logic cond_ok(input logic [3:0] c);
        case (c)
            4'h0: return !fl[3];
            4'h1: return fl[3];
            4'h2: return !fl[3] && !fl[2];
            4'h3: return !fl[2];
            4'h4: return fl[2];
            4'h5: return fl[3] && fl[2];
            4'ha: return fl[6];
            4'hb: return !fl[6];
            4'hc: return fl[1];
            4'hd: return fl[0];
            4'he, 4'hf: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic cmov(input logic [2:0] op, input logic [3:0] c, input logic cg,
                        input logic [2:0] d, input logic [2:0] s, input logic [31:0] w);
        logic [31:0] v;
        v = (op == 3'h4) ? w : fr[s];
        ok = cond_ok(cg ? c : 4'hf);
        issue(op, c, cg, d, s, w);
        if (ok) fr[d] = v;
        if (!cg || c == 4'hf) fl[5:2] = {v == 0, v[31], v[30:23] == 0, v[31] && v[30:23] != 0};
        // flags land at the edge after the taking edge
        @(posedge aclk);
        #1 cmp(fpu_status_register, fl);
    endtask
    task automatic readout(input logic [2:0] s);
        issue(3'h0, 4'he, 1'b1, 3'h0, s, 32'h0);
        @(posedge aclk);
        #1 cmp(host_prod_we, 1);
        cmp(host_prod_out, fr[s]);
        @(posedge aclk);
        #1 cmp(host_prod_in, fr[s]);
        cmp(fpu_status_register, fl);
    endtask
    task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            do @(posedge aclk); while (s_axi_awready !== 1 || s_axi_wready !== 1);
            s_axi_awvalid <= 0; s_axi_wvalid <= 0;
            do @(posedge aclk); while (s_axi_bvalid !== 1);
            rs = s_axi_bresp; s_axi_bready <= 0;
        end else begin
            s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
            do @(posedge aclk); while (s_axi_arready !== 1);
            s_axi_arvalid <= 0;
            do @(posedge aclk); while (s_axi_rvalid !== 1);
            rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
        end
    endtask
    // watchdog: the sequence needs a few thousand cycles at most
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            cmov(3'h4, 4'h0, 1'b0, 3'h1, 3'h0,
                 i[2:0] == 0 ? 32'h0 : rnd[7] ? rnd & 32'h807fffff : rnd);
            rnd = lfsr(rnd);
            cmov(i[4] ? 3'h5 : 3'h4, i[3:0], 1'b1, 3'h2, 3'h1, rnd);
            readout(3'h2);
        end
        issue(3'h1, 4'he, 1'b1, 3'h0, 3'h2, 32'h0);
        repeat (2) @(posedge aclk);
        #1 cmp(host_acc_in, fr[2]);
        issue(3'h2, 4'he, 1'b1, 3'h3, 3'h0, 32'h0);
        fr[3] = fr[2];
        #1 cmp(reg_pending, 8'h08);
        // a conversion inside the four-cycle shadow must be reported
        issue(3'h6, 4'he, 1'b1, 3'h0, 3'h0, 32'h0);
        repeat (2) @(posedge aclk);
        readout(3'h3);
        cmp(irq, 0);
        axi(1, 5'h0c, 32'h1);
        #1 cmp(irq, 1);
        axi(0, 5'h08, 0);
        cmp(rd[4], 1);
        axi(1, 5'h08, 32'h3f);
        #1 cmp(irq, 0);
        axi(0, 5'h04, 0);
        cmp(rd, fl);
        axi(0, 5'h14, 0);
        cmp(rs, 2'h2);
        close_out();
    end
endmodule
